// [core/cpb_param_bank.v]
// Camera parameter bank: gain, black level, white balance, tap layout,
// user sets, three event counters and three 256-entry lookup tables.
// Assumes an AXI4-Lite master on sys_clk and event pulses from same-clock logic.
//
// Notes on behaviour
// RULE_01: Analog gain holds 100 to 1600, is 100 after reset and is read/write.
// RULE_02: On colour builds red and blue white-balance gains hold -4533 to 28400, reset 0.
// RULE_03: Auto gain mode is 0 for off and 1 for continuous, reset 0.
// RULE_04: Overall black level holds -133 to 255, reset 0.
// RULE_05: On colour builds red and blue black offsets hold -133 to 255, reset 0.
// RULE_06: Auto white mode decodes 0 to 5 as off, once, continuous, 4600K, 5600K, 6500K; others are off.
// RULE_07: Each channel has a 256-entry table of 12-bit data that resets to a unity curve.
// RULE_08: On mono builds the green table is applied to the whole image.
// RULE_09: Tap layout accepts 0, 1, 3, 5 and 7 for 1, 2, 4, 8 and 3 taps, reset 3.
// RULE_10: Recall of 0 loads factory defaults, recall of 1 to 3 loads that user set.
// RULE_11: Store copies current settings into user set 1 to 3; 0 is refused.
// RULE_12: Each counter source decodes 0 off, 1 trigger, 2 frame start, 3 exposure start, 4 transfer end.
// RULE_13: Writing 1 to a counter clear zeroes only that counter; the code loads 1 instead when its selected event fires in the clear cycle.
// RULE_14: Counter values are read-only, 16 bits wide and 0 after reset.
// RULE_15: A counter adds one per selected event and holds while its source is off.
// RULE_16: A write with a value out of range leaves the setting unchanged; auto white mode instead stores values above five as off.
`timescale 1ns/1ps
`include "cpb_consts.vh"

module cpb_param_bank #(
   parameter COLOR = 1
) (
   input  wire        sys_clk,
   input  wire        reset_n,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        ev_frame_trigger,
   input  wire        ev_frame_start,
   input  wire        ev_exposure_start,
   input  wire        ev_transfer_end,
   input  wire [7:0]  pix_red,
   input  wire [7:0]  pix_green,
   input  wire [7:0]  pix_blue,
   output reg  [11:0] lut_out_red,
   output reg  [11:0] lut_out_green,
   output reg  [11:0] lut_out_blue,
   output wire [10:0] analog_gain_all,
   output wire [15:0] wb_gain_red,
   output wire [15:0] wb_gain_blue,
   output wire        auto_gain_mode,
   output wire [9:0]  dark_offset_all,
   output wire [9:0]  dark_offset_red,
   output wire [9:0]  dark_offset_blue,
   output wire [2:0]  auto_white_eff,
   output reg  [3:0]  tap_count
);

   localparam SW = `CPB_SET_W;

   reg  [7:0]    aw_addr_q;
   reg           aw_full_q;
   reg  [31:0]   w_data_q;
   reg           w_full_q;
   reg           bvalid_q;
   reg  [1:0]    bresp_q;
   reg           rvalid_q;
   reg  [31:0]   rdata_q;
   reg  [1:0]    rresp_q;
   reg  [31:0]   rdata_d;
   reg           rerr_d;
   reg  [SW-1:0] set_q;
   reg  [SW-1:0] uset_q [1:3];
   reg  [1:0]    recall_q;
   reg  [1:0]    store_q;
   reg  [7:0]    lut_idx_q;
   reg  [2:0]    awb_raw;
   wire [SW-1:0] def_set;
   wire          wr_fire;
   wire [7:0]    wa;
   wire [31:0]   wd;
   wire signed [31:0] sd;
   wire [7:0]    ra;
   wire [2:0]    clr_hit;
   wire [47:0]   cnt_all;
   wire [3071:0] lut_r_flat;
   wire [3071:0] lut_g_flat;
   wire [3071:0] lut_b_flat;
   wire          lut_ok;
   wire          col;

   assign col     = (COLOR != 0);
   assign def_set = {{(SW - `CPB_TAP_LSB - 3){1'b0}}, `CPB_TAP_RST,
                     {(`CPB_TAP_LSB - 11){1'b0}}, `CPB_GAIN_RST};

   // Bus handshake outputs
   assign s_axi_awready = ~aw_full_q;
   assign s_axi_wready  = ~w_full_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = ~rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   assign wr_fire = aw_full_q & w_full_q & ~bvalid_q;
   assign wa      = {aw_addr_q[7:2], 2'h0};
   assign wd      = w_data_q;
   assign sd      = w_data_q;
   assign ra      = {s_axi_araddr[7:2], 2'h0};
   assign lut_ok  = (wd <= `CPB_LUT_MAX);

   // Setting fields driven out of the live vector
   assign analog_gain_all  = set_q[`CPB_GAIN_LSB +: 11];
   assign wb_gain_red      = set_q[`CPB_WBR_LSB +: 16];
   assign wb_gain_blue     = set_q[`CPB_WBB_LSB +: 16];
   assign auto_gain_mode   = set_q[`CPB_AGC_LSB];
   assign dark_offset_all  = set_q[`CPB_BL_LSB +: 10];
   assign dark_offset_red  = set_q[`CPB_BLR_LSB +: 10];
   assign dark_offset_blue = set_q[`CPB_BLB_LSB +: 10];
   assign auto_white_eff   = (set_q[`CPB_AWB_LSB +: 3] <= `CPB_AWB_MAX) ? set_q[`CPB_AWB_LSB +: 3] : 3'h0; // [RULE_06]

   // Values above five are stored as off
   always @* begin
      awb_raw = (wd <= `CPB_AWB_MAX) ? wd[2:0] : 3'h0; // [RULE_06]
   end

   // Tap layout code to number of taps
   always @* begin
      case (set_q[`CPB_TAP_LSB +: 3]) // [RULE_09]
         3'h0:    tap_count = 4'h1;
         3'h1:    tap_count = 4'h2;
         3'h3:    tap_count = 4'h4;
         3'h5:    tap_count = 4'h8;
         3'h7:    tap_count = 4'h3;
         default: tap_count = 4'h4;
      endcase
   end

   // Address and data capture, write response
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_full_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_full_q  <= 1'b0;
         w_data_q  <= 32'h0;
         bvalid_q  <= 1'b0;
      end else begin
         if (s_axi_awvalid && !aw_full_q) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_full_q) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata;
         end
         if (wr_fire) begin
            bvalid_q <= 1'b1;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q  <= 1'b0;
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
         end
      end
   end

   // Settings, user sets and write checks
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         set_q     <= {{(SW - `CPB_TAP_LSB - 3){1'b0}}, `CPB_TAP_RST, {(`CPB_TAP_LSB - 11){1'b0}}, `CPB_GAIN_RST};
         uset_q[1] <= {{(SW - `CPB_TAP_LSB - 3){1'b0}}, `CPB_TAP_RST, {(`CPB_TAP_LSB - 11){1'b0}}, `CPB_GAIN_RST};
         uset_q[2] <= {{(SW - `CPB_TAP_LSB - 3){1'b0}}, `CPB_TAP_RST, {(`CPB_TAP_LSB - 11){1'b0}}, `CPB_GAIN_RST};
         uset_q[3] <= {{(SW - `CPB_TAP_LSB - 3){1'b0}}, `CPB_TAP_RST, {(`CPB_TAP_LSB - 11){1'b0}}, `CPB_GAIN_RST};
         recall_q  <= 2'h0;
         store_q   <= `CPB_STORE_RST;
         lut_idx_q <= 8'h00;
         bresp_q   <= `CPB_RESP_OK;
      end else if (wr_fire) begin
         bresp_q <= `CPB_RESP_OK;
         case (wa)
            `CPB_ADR_GAIN:
               if (sd >= `CPB_GAIN_MIN && sd <= `CPB_GAIN_MAX) set_q[`CPB_GAIN_LSB +: 11] <= wd[10:0]; // [RULE_01]
               else bresp_q <= `CPB_RESP_ERR; // [RULE_16]
            `CPB_ADR_WB_RED:
               if (col && sd >= `CPB_WB_MIN && sd <= `CPB_WB_MAX) set_q[`CPB_WBR_LSB +: 16] <= wd[15:0]; // [RULE_02]
               else bresp_q <= `CPB_RESP_ERR; // [RULE_16]
            `CPB_ADR_WB_BLUE:
               if (col && sd >= `CPB_WB_MIN && sd <= `CPB_WB_MAX) set_q[`CPB_WBB_LSB +: 16] <= wd[15:0]; // [RULE_02]
               else bresp_q <= `CPB_RESP_ERR;
            `CPB_ADR_AGC:
               if (wd <= 32'h1) set_q[`CPB_AGC_LSB] <= wd[0]; // [RULE_03]
               else bresp_q <= `CPB_RESP_ERR; // [RULE_16]
            `CPB_ADR_DARK_ALL:
               if (sd >= `CPB_DARK_MIN && sd <= `CPB_DARK_MAX) set_q[`CPB_BL_LSB +: 10] <= wd[9:0]; // [RULE_04]
               else bresp_q <= `CPB_RESP_ERR; // [RULE_16]
            `CPB_ADR_DARK_RED:
               if (col && sd >= `CPB_DARK_MIN && sd <= `CPB_DARK_MAX) set_q[`CPB_BLR_LSB +: 10] <= wd[9:0]; // [RULE_05]
               else bresp_q <= `CPB_RESP_ERR;
            `CPB_ADR_DARK_BLUE:
               if (col && sd >= `CPB_DARK_MIN && sd <= `CPB_DARK_MAX) set_q[`CPB_BLB_LSB +: 10] <= wd[9:0]; // [RULE_05]
               else bresp_q <= `CPB_RESP_ERR;
            `CPB_ADR_AWB:
               if (col) set_q[`CPB_AWB_LSB +: 3] <= awb_raw; // [RULE_06]
               else bresp_q <= `CPB_RESP_ERR;
            `CPB_ADR_TAP:
               if (wd == 32'h0 || wd == 32'h1 || wd == 32'h3 || wd == 32'h5 || wd == 32'h7)
                  set_q[`CPB_TAP_LSB +: 3] <= wd[2:0]; // [RULE_09]
               else bresp_q <= `CPB_RESP_ERR; // [RULE_16]
            `CPB_ADR_RECALL:
               if (wd <= 32'h3) begin
                  recall_q <= wd[1:0];
                  set_q    <= (wd[1:0] == 2'h0) ? def_set : uset_q[wd[1:0]]; // [RULE_10]
               end else bresp_q <= `CPB_RESP_ERR;
            `CPB_ADR_STORE:
               if (wd >= 32'h1 && wd <= 32'h3) begin
                  store_q           <= wd[1:0];
                  uset_q[wd[1:0]]   <= set_q; // [RULE_11]
               end else bresp_q <= `CPB_RESP_ERR; // [RULE_11]
            `CPB_ADR_LUT_IDX:
               if (wd <= `CPB_IDX_MAX) lut_idx_q <= wd[7:0];
               else bresp_q <= `CPB_RESP_ERR;
            `CPB_ADR_LUT_GREEN:
               if (!lut_ok) bresp_q <= `CPB_RESP_ERR; // [RULE_16]
            `CPB_ADR_LUT_RED, `CPB_ADR_LUT_BLUE:
               if (!lut_ok || !col) bresp_q <= `CPB_RESP_ERR; // [RULE_08]
            `CPB_ADR_SRC0, `CPB_ADR_SRC0 + 8'h04, `CPB_ADR_SRC0 + 8'h08:
               if (wd <= `CPB_SRC_MAX) set_q[`CPB_SRC_LSB + 3 * ((wa - `CPB_ADR_SRC0) >> 2) +: 3] <= wd[2:0]; // [RULE_12]
               else bresp_q <= `CPB_RESP_ERR; // [RULE_16]
            `CPB_ADR_CLR0, `CPB_ADR_CLR0 + 8'h04, `CPB_ADR_CLR0 + 8'h08:
               if (wd != 32'h1) bresp_q <= `CPB_RESP_ERR;
            default:
               bresp_q <= `CPB_RESP_ERR; // Unmapped or read-only
         endcase
      end
   end

   // Counter clear strobes, one per counter
   assign clr_hit[0] = wr_fire && wa == `CPB_ADR_CLR0 && wd == 32'h1; // [RULE_13]
   assign clr_hit[1] = wr_fire && wa == `CPB_ADR_CLR0 + 8'h04 && wd == 32'h1; // [RULE_13]
   assign clr_hit[2] = wr_fire && wa == `CPB_ADR_CLR0 + 8'h08 && wd == 32'h1; // [RULE_13]

   // Event counters; an event in the clear cycle counts as the first
   genvar c;
   generate
      for (c = 0; c < 3; c = c + 1) begin : g_cnt
         reg  [15:0] cnt_q;
         wire [2:0]  src;
         reg         hit;
         assign src = set_q[`CPB_SRC_LSB + 3 * c +: 3];
         always @* begin
            case (src) // [RULE_12]
               3'h1:    hit = ev_frame_trigger;
               3'h2:    hit = ev_frame_start;
               3'h3:    hit = ev_exposure_start;
               3'h4:    hit = ev_transfer_end;
               default: hit = 1'b0; // Off holds the count [RULE_15]
            endcase
         end
         always @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
               cnt_q <= 16'h0000; // [RULE_14]
            end else if (clr_hit[c]) begin
               cnt_q <= {15'h0000, hit}; // [RULE_13]
            end else if (hit) begin
               cnt_q <= cnt_q + 16'h0001; // [RULE_15]
            end
         end
         assign cnt_all[16 * c +: 16] = cnt_q;
      end
   endgenerate

   // Lookup tables, one flop word per entry, reset to a unity curve
   genvar e;
   generate
      for (e = 0; e < 256; e = e + 1) begin : g_lut
         localparam [11:0] UNITY = (e * 4095) / 255;
         reg [11:0] r_q;
         reg [11:0] g_q;
         reg [11:0] b_q;
         wire       hit_e;
         assign hit_e = wr_fire && lut_ok && lut_idx_q == e;
         always @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
               r_q <= UNITY; // [RULE_07]
               g_q <= UNITY;
               b_q <= UNITY;
            end else begin
               if (hit_e && col && wa == `CPB_ADR_LUT_RED) r_q <= wd[11:0]; // [RULE_07]
               if (hit_e && wa == `CPB_ADR_LUT_GREEN) g_q <= wd[11:0];
               if (hit_e && col && wa == `CPB_ADR_LUT_BLUE) b_q <= wd[11:0];
            end
         end
         assign lut_r_flat[12 * e +: 12] = r_q;
         assign lut_g_flat[12 * e +: 12] = g_q;
         assign lut_b_flat[12 * e +: 12] = b_q;
      end
   endgenerate

   // Pixel lookup; mono builds use the green table on every channel
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         lut_out_red   <= 12'h000;
         lut_out_green <= 12'h000;
         lut_out_blue  <= 12'h000;
      end else begin
         lut_out_green <= lut_g_flat[12 * pix_green +: 12];
         lut_out_red   <= col ? lut_r_flat[12 * pix_red +: 12] : lut_g_flat[12 * pix_red +: 12]; // [RULE_08]
         lut_out_blue  <= col ? lut_b_flat[12 * pix_blue +: 12] : lut_g_flat[12 * pix_blue +: 12]; // [RULE_08]
      end
   end

   // Read decode
   always @* begin
      rdata_d = 32'h0;
      rerr_d  = 1'b0;
      case (ra)
         `CPB_ADR_GAIN:      rdata_d = {21'h0, analog_gain_all};
         `CPB_ADR_WB_RED:    rdata_d = {{16{wb_gain_red[15]}}, wb_gain_red};
         `CPB_ADR_WB_BLUE:   rdata_d = {{16{wb_gain_blue[15]}}, wb_gain_blue};
         `CPB_ADR_AGC:       rdata_d = {31'h0, auto_gain_mode};
         `CPB_ADR_DARK_ALL:  rdata_d = {{22{dark_offset_all[9]}}, dark_offset_all};
         `CPB_ADR_DARK_RED:  rdata_d = {{22{dark_offset_red[9]}}, dark_offset_red};
         `CPB_ADR_DARK_BLUE: rdata_d = {{22{dark_offset_blue[9]}}, dark_offset_blue};
         `CPB_ADR_AWB:       rdata_d = {29'h0, set_q[`CPB_AWB_LSB +: 3]};
         `CPB_ADR_TAP:       rdata_d = {29'h0, set_q[`CPB_TAP_LSB +: 3]};
         `CPB_ADR_RECALL:    rdata_d = {30'h0, recall_q};
         `CPB_ADR_STORE:     rdata_d = {30'h0, store_q};
         `CPB_ADR_LUT_IDX:   rdata_d = {24'h0, lut_idx_q};
         `CPB_ADR_LUT_RED:   rdata_d = {20'h0, lut_r_flat[12 * lut_idx_q +: 12]};
         `CPB_ADR_LUT_GREEN: rdata_d = {20'h0, lut_g_flat[12 * lut_idx_q +: 12]};
         `CPB_ADR_LUT_BLUE:  rdata_d = {20'h0, lut_b_flat[12 * lut_idx_q +: 12]};
         `CPB_ADR_SRC0:          rdata_d = {29'h0, set_q[`CPB_SRC_LSB +: 3]};
         `CPB_ADR_SRC0 + 8'h04:  rdata_d = {29'h0, set_q[`CPB_SRC_LSB + 3 +: 3]};
         `CPB_ADR_SRC0 + 8'h08:  rdata_d = {29'h0, set_q[`CPB_SRC_LSB + 6 +: 3]};
         `CPB_ADR_CLR0, `CPB_ADR_CLR0 + 8'h04, `CPB_ADR_CLR0 + 8'h08: rdata_d = 32'h0;
         `CPB_ADR_CNT0:          rdata_d = {16'h0, cnt_all[15:0]}; // [RULE_14]
         `CPB_ADR_CNT0 + 8'h04:  rdata_d = {16'h0, cnt_all[31:16]};
         `CPB_ADR_CNT0 + 8'h08:  rdata_d = {16'h0, cnt_all[47:32]};
         default:            rerr_d  = 1'b1;
      endcase
   end

   // Read data channel
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0;
         rresp_q  <= `CPB_RESP_OK;
      end else if (s_axi_arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rdata_d;
         rresp_q  <= rerr_d ? `CPB_RESP_ERR : `CPB_RESP_OK;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

endmodule

// [core/cpb_consts.vh]
// Constants of the camera parameter bank: register byte offsets, field
// positions inside the packed settings vector, value ranges and defaults.
// Assumes a 32-bit AXI4-Lite bus with one aligned word per register.
`ifndef CPB_CONSTS_VH
`define CPB_CONSTS_VH

// Register byte offsets
`define CPB_ADR_GAIN      8'h00
`define CPB_ADR_WB_RED    8'h04
`define CPB_ADR_WB_BLUE   8'h08
`define CPB_ADR_AGC       8'h0c
`define CPB_ADR_DARK_ALL  8'h10
`define CPB_ADR_DARK_RED  8'h14
`define CPB_ADR_DARK_BLUE 8'h18
`define CPB_ADR_AWB       8'h1c
`define CPB_ADR_TAP       8'h20
`define CPB_ADR_RECALL    8'h24
`define CPB_ADR_STORE     8'h28
`define CPB_ADR_LUT_IDX   8'h2c
`define CPB_ADR_LUT_RED   8'h30
`define CPB_ADR_LUT_GREEN 8'h34
`define CPB_ADR_LUT_BLUE  8'h38
`define CPB_ADR_SRC0      8'h3c
`define CPB_ADR_CLR0      8'h48
`define CPB_ADR_CNT0      8'h54

// Packed settings vector: field LSB positions and total width
`define CPB_GAIN_LSB  0
`define CPB_WBR_LSB   11
`define CPB_WBB_LSB   27
`define CPB_AGC_LSB   43
`define CPB_BL_LSB    44
`define CPB_BLR_LSB   54
`define CPB_BLB_LSB   64
`define CPB_AWB_LSB   74
`define CPB_TAP_LSB   77
`define CPB_SRC_LSB   80
`define CPB_SET_W     89

// Value ranges
`define CPB_GAIN_MIN  100
`define CPB_GAIN_MAX  1600
`define CPB_WB_MIN    -4533
`define CPB_WB_MAX    28400
`define CPB_DARK_MIN  -133
`define CPB_DARK_MAX  255
`define CPB_AWB_MAX   5
`define CPB_SRC_MAX   4
`define CPB_LUT_MAX   4095
`define CPB_IDX_MAX   255

// Reset values
`define CPB_GAIN_RST  11'h064
`define CPB_TAP_RST   3'h3
`define CPB_STORE_RST 2'h1

// AXI responses
`define CPB_RESP_OK   2'h0
`define CPB_RESP_ERR  2'h2

`endif

// [testbench/cpb_param_bank_assertions.sv]
// Checker for the camera parameter bank: bus handshakes and setting outputs.
// Assumes it is bound into cpb_param_bank and sees only its ports.
`timescale 1ns/1ps
module cpb_param_bank_assertions (
   input wire        sys_clk,
   input wire        reset_n,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire [10:0] analog_gain_all,
   input wire [2:0]  auto_white_eff,
   input wire [3:0]  tap_count
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   // Both halves of a write taken at one edge
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // A response or read word still waiting for the master
   sequence resp_wait;
      s_axi_bvalid && !s_axi_bready;
   endsequence
   sequence data_wait;
      s_axi_rvalid && !s_axi_rready;
   endsequence

   wr_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   resp_hold_a: assert property (resp_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during response");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   rd_hold_a: assert property (data_wait |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data changed");
   rd_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data not released");
   gain_range_a: assert property (analog_gain_all >= 11'd100 && analog_gain_all <= 11'd1600)
      else $error("gain out of range");
   awb_range_a: assert property (auto_white_eff <= 3'd5)
      else $error("white mode out of range");
   tap_legal_a: assert property (tap_count inside {4'd1, 4'd2, 4'd3, 4'd4, 4'd8})
      else $error("tap count illegal");
endmodule

bind cpb_param_bank cpb_param_bank_assertions chk_u (.sys_clk, .reset_n, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .analog_gain_all, .auto_white_eff, .tap_count);

// [testbench/tb.sv]
// Self-checking bench for the camera parameter bank over AXI4-Lite.
// Assumes cpb_consts.vh on the include path and the checker compiled before.
`timescale 1ns/1ps
`include "cpb_consts.vh"
module tb;
   reg         sys_clk = 1'b0;
   reg         reset_n = 1'b0;
   reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   reg  [31:0] s_axi_wdata = 32'h0;
   reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   reg  [3:0]  ev_q = 4'h0;
   reg  [7:0]  pix_red = 8'h00, pix_green = 8'h00, pix_blue = 8'h00;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, auto_gain_mode;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [11:0] lut_out_red, lut_out_green, lut_out_blue;
   wire [10:0] analog_gain_all;
   wire [15:0] wb_gain_red, wb_gain_blue;
   wire [9:0]  dark_offset_all, dark_offset_red, dark_offset_blue;
   wire [2:0]  auto_white_eff;
   wire [3:0]  tap_count;
   integer     fail_count = 0, num_checks = 0, cycles = 0, i;
   reg  [31:0] exp_tap;

   // Colour build under test
   cpb_param_bank #(.COLOR(1)) dut_u (.sys_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .ev_frame_trigger(ev_q[0]), .ev_frame_start(ev_q[1]),
      .ev_exposure_start(ev_q[2]), .ev_transfer_end(ev_q[3]), .pix_red, .pix_green, .pix_blue,
      .lut_out_red, .lut_out_green, .lut_out_blue, .analog_gain_all, .wb_gain_red, .wb_gain_blue,
      .auto_gain_mode, .dark_offset_all, .dark_offset_red, .dark_offset_blue, .auto_white_eff, .tap_count);

   // 200 MHz clock
   always #2.5 sys_clk = ~sys_clk;

   // Hang guard
   always @(posedge sys_clk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         fail_count = fail_count + 1;
         stop_test;
      end
   end

   task check(input string nm, input [31:0] seen, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask

   // Write with address and data offered together, response checked
   task wr(input [7:0] a, input [31:0] d, input [1:0] er);
      reg [2:0] hs;
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         // Handshakes sampled mid-cycle, acted on at the next rising edge
         do begin
            @(negedge sys_clk);
            hs = {s_axi_bvalid === 1'b1, s_axi_awvalid && s_axi_awready, s_axi_wvalid && s_axi_wready};
            if (hs[2]) check($sformatf("bresp %h", a), {30'h0, s_axi_bresp}, {30'h0, er});
            @(posedge sys_clk);
            if (hs[1]) s_axi_awvalid <= 1'b0;
            if (hs[0]) s_axi_wvalid <= 1'b0;
         end while (!hs[2]);
         s_axi_bready <= 1'b0;
         @(posedge sys_clk);
      end
   endtask

   task rd(input [7:0] a, input [31:0] exp, input [1:0] er);
      reg [1:0] hs;
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         do begin
            @(negedge sys_clk);
            hs = {s_axi_rvalid === 1'b1, s_axi_arvalid && s_axi_arready};
            if (hs[1]) begin
               check($sformatf("rdata %h", a), s_axi_rdata, exp);
               check($sformatf("rresp %h", a), {30'h0, s_axi_rresp}, {30'h0, er});
            end
            @(posedge sys_clk);
            if (hs[0]) s_axi_arvalid <= 1'b0;
         end while (!hs[1]);
         s_axi_rready <= 1'b0;
         @(posedge sys_clk);
      end
   endtask

   task wrr(input [7:0] a, input [31:0] d, input [1:0] er, input [31:0] rb);
      begin
         wr(a, d, er);
         rd(a, rb, 2'h0);
      end
   endtask

   // Holds the chosen event lines high for k cycles
   task pulse(input [3:0] m, input integer k);
      begin
         ev_q <= m;
         repeat (k) @(posedge sys_clk);
         ev_q <= 4'h0;
         @(posedge sys_clk);
      end
   endtask

   task stop_test;
      begin
         $display("checks %0d mismatches %0d", num_checks, fail_count);
         if (fail_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask

   // Main sequence
   initial begin
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      rd(`CPB_ADR_GAIN, 32'h64, 2'h0);
      rd(`CPB_ADR_WB_BLUE, 32'h0, 2'h0);
      rd(`CPB_ADR_AGC, 32'h0, 2'h0);
      rd(`CPB_ADR_DARK_ALL, 32'h0, 2'h0);
      rd(`CPB_ADR_DARK_RED, 32'h0, 2'h0);
      rd(`CPB_ADR_AWB, 32'h0, 2'h0);
      rd(`CPB_ADR_SRC0, 32'h0, 2'h0);
      rd(`CPB_ADR_CNT0, 32'h0, 2'h0);
      check("tap_count", tap_count, 32'h4);
      $display("test reset values done");
      wrr(`CPB_ADR_GAIN, 32'h640, 2'h0, 32'h640);
      wrr(`CPB_ADR_GAIN, 32'h641, 2'h2, 32'h640);
      wrr(`CPB_ADR_GAIN, 32'h63, 2'h2, 32'h640);
      check("analog_gain_all", analog_gain_all, 32'h640);
      wrr(`CPB_ADR_WB_RED, 32'hffffee4b, 2'h0, 32'hffffee4b);
      wrr(`CPB_ADR_WB_RED, 32'hffffee4a, 2'h2, 32'hffffee4b);
      wrr(`CPB_ADR_WB_BLUE, 32'h6ef0, 2'h0, 32'h6ef0);
      wrr(`CPB_ADR_WB_BLUE, 32'h6ef1, 2'h2, 32'h6ef0);
      wrr(`CPB_ADR_AGC, 32'h1, 2'h0, 32'h1);
      wrr(`CPB_ADR_AGC, 32'h2, 2'h2, 32'h1);
      wrr(`CPB_ADR_DARK_ALL, 32'hffffff7b, 2'h0, 32'hffffff7b);
      wrr(`CPB_ADR_DARK_ALL, 32'h100, 2'h2, 32'hffffff7b);
      wrr(`CPB_ADR_DARK_RED, 32'hff, 2'h0, 32'hff);
      wrr(`CPB_ADR_DARK_BLUE, 32'hffffff7a, 2'h2, 32'h0);
      check("wb_gain_blue", wb_gain_blue, 32'h6ef0);
      check("auto_gain_mode", auto_gain_mode, 32'h1);
      check("dark_offset_all", dark_offset_all, 32'h37b);
      rd(8'h80, 32'h0, 2'h2);
      wr(8'h80, 32'h1, 2'h2);
      $display("test ranges done");
      for (i = 0; i < 7; i = i + 1) begin
         wr(`CPB_ADR_AWB, i, 2'h0);
         check("auto_white_eff", auto_white_eff, (i < 6) ? i : 0);
      end
      exp_tap = 32'h4;
      for (i = 0; i < 8; i = i + 1) begin
         exp_tap = (i == 0) ? 1 : (i == 1) ? 2 : (i == 3) ? 4 : (i == 5) ? 8 : (i == 7) ? 3 : exp_tap;
         wr(`CPB_ADR_TAP, i, (i == 2 || i == 4 || i == 6) ? 2'h2 : 2'h0);
         check("tap_count", tap_count, exp_tap);
      end
      $display("test modes done");
      wr(`CPB_ADR_LUT_IDX, 32'ha, 2'h0);
      rd(`CPB_ADR_LUT_GREEN, 32'ha0, 2'h0);
      wrr(`CPB_ADR_LUT_GREEN, 32'hfff, 2'h0, 32'hfff);
      wrr(`CPB_ADR_LUT_GREEN, 32'h1000, 2'h2, 32'hfff);
      wr(`CPB_ADR_LUT_IDX, 32'h100, 2'h2);
      pix_red <= 8'h0a;
      pix_green <= 8'h0a;
      pix_blue <= 8'hff;
      repeat (2) @(posedge sys_clk);
      check("lut_out_green", lut_out_green, 32'hfff);
      check("lut_out_red", lut_out_red, 32'ha0);
      check("lut_out_blue", lut_out_blue, 32'hfff);
      $display("test tables done");
      wr(`CPB_ADR_SRC0, 32'h2, 2'h0);
      for (i = 1; i < 5; i = i + 1) begin
         wr(`CPB_ADR_SRC0 + 8'h08, i, 2'h0);
         wr(`CPB_ADR_CLR0 + 8'h08, 32'h1, 2'h0);
         pulse(4'hf, 1);
         pulse(4'h1 << (i - 1), 2);
         rd(`CPB_ADR_CNT0 + 8'h08, 32'h3, 2'h0);
      end
      rd(`CPB_ADR_CNT0, 32'h6, 2'h0);
      rd(`CPB_ADR_CNT0 + 8'h04, 32'h0, 2'h0);
      wr(`CPB_ADR_CLR0, 32'h1, 2'h0);
      rd(`CPB_ADR_CNT0, 32'h0, 2'h0);
      rd(`CPB_ADR_CNT0 + 8'h08, 32'h3, 2'h0);
      wr(`CPB_ADR_CLR0 + 8'h08, 32'h2, 2'h2);
      wr(`CPB_ADR_CNT0 + 8'h08, 32'h0, 2'h2);
      wrr(`CPB_ADR_SRC0, 32'h5, 2'h2, 32'h2);
      $display("test counters done");
      wrr(`CPB_ADR_GAIN, 32'h1f4, 2'h0, 32'h1f4);
      wr(`CPB_ADR_STORE, 32'h2, 2'h0);
      wrr(`CPB_ADR_STORE, 32'h0, 2'h2, 32'h2);
      wrr(`CPB_ADR_GAIN, 32'h2bc, 2'h0, 32'h2bc);
      wr(`CPB_ADR_RECALL, 32'h2, 2'h0);
      rd(`CPB_ADR_GAIN, 32'h1f4, 2'h0);
      rd(`CPB_ADR_SRC0, 32'h2, 2'h0);
      wr(`CPB_ADR_RECALL, 32'h1, 2'h0);
      rd(`CPB_ADR_GAIN, 32'h64, 2'h0);
      wr(`CPB_ADR_RECALL, 32'h2, 2'h0);
      wr(`CPB_ADR_RECALL, 32'h0, 2'h0);
      rd(`CPB_ADR_GAIN, 32'h64, 2'h0);
      rd(`CPB_ADR_SRC0, 32'h0, 2'h0);
      wr(`CPB_ADR_RECALL, 32'h4, 2'h2);
      $display("test user sets done");
      stop_test;
   end
endmodule
